// file: design/cactl_sync.sv
// three-stage synchroniser with falling and rising edge pulses
// assumes an asynchronous input and one system clock
`timescale 1ns/10ps
module cactl_sync (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic async_in,
    output logic rise,
    output logic fall
);
    logic [2:0] stage;
    logic [2:0] fill;

    // the edge is judged on stages two and three only, never on stage one
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], async_in};
        end
    end

    // edges are held off until every stage carries the pin, so the reset
    // value of the stages can never pose as an edge of a pin idling high
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fill <= 3'h0;
        end else begin
            fill <= {fill[1:0], 1'b1};
        end
    end

    assign rise = fill[2] & stage[1] & ~stage[2];
    assign fall = fill[2] & ~stage[1] & stage[2];
endmodule

// file: design/cactl_top.sv
// control and status for the counter array's shared 16-bit counter
// assumes a single-cycle register port; timer 0 overflow is a same-clock pulse
`timescale 1ns/10ps
module cactl_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic cpu_idle,
    input wire logic [2:0] module_match_event,
    input wire logic [2:0] module_irq_enable,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic external_clock,
    input wire logic lfo_clock,
    output logic [15:0] shared_array_counter,
    output logic count_tick,
    output logic array_active,
    output logic array_irq
);
    logic counter_overflow_flag;
    logic counter_run_bit;
    logic [2:0] module_match_flag;
    logic idle_suspend_bit;
    logic [2:0] timebase_select;
    logic overflow_irq_enable;
    logic [3:0] div12_cnt;
    logic [1:0] div4_cnt;
    logic [2:0] ext8_cnt;
    logic [2:0] lfo8_cnt;
    logic eci_fall;
    logic extclk_rise;
    logic lfo_rise;
    logic next_tick;
    logic wrap;
    logic wr_ctrl;
    logic wr_mode;

    assign wr_ctrl = reg_wr && (reg_addr == cactl_pkg::ctrl_addr);
    assign wr_mode = reg_wr && (reg_addr == cactl_pkg::mode_addr);

    // suspended only when both the bit and the processor idle are set
    assign array_active = ~(idle_suspend_bit & cpu_idle);

    cactl_sync u_eci (
        .core_clk(core_clk),
        .nrst(nrst),
        .async_in(external_count_input),
        .rise(),
        .fall(eci_fall)
    );

    cactl_sync u_extclk (
        .core_clk(core_clk),
        .nrst(nrst),
        .async_in(external_clock),
        .rise(extclk_rise),
        .fall()
    );

    cactl_sync u_lfo (
        .core_clk(core_clk),
        .nrst(nrst),
        .async_in(lfo_clock),
        .rise(lfo_rise),
        .fall()
    );

    // prescalers free-run while active so a source switch picks up a live rate
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div12_cnt <= 4'h0;
        end else if (array_active) begin
            div12_cnt <= (div12_cnt == cactl_pkg::div12_last) ? 4'h0 : div12_cnt + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div4_cnt <= 2'h0;
        end else if (array_active) begin
            div4_cnt <= div4_cnt + 2'h1;
        end
    end

    // divide-by-8 stages count source edges, so a stopped source freezes them
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext8_cnt <= 3'h0;
        end else if (array_active && extclk_rise) begin
            ext8_cnt <= ext8_cnt + 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lfo8_cnt <= 3'h0;
        end else if (array_active && lfo_rise) begin
            lfo8_cnt <= lfo8_cnt + 3'h1;
        end
    end

    always_comb begin
        next_tick = 1'b0;
        unique case (cactl_pkg::cactl_sel_e'(timebase_select))
            cactl_pkg::cactl_sel_div12: next_tick = (div12_cnt == cactl_pkg::div12_last);
            cactl_pkg::cactl_sel_div4: next_tick = (div4_cnt == cactl_pkg::div4_last);
            cactl_pkg::cactl_sel_tmr0: next_tick = timer0_overflow;
            // the source must respect clock div 4 or edges are merged
            cactl_pkg::cactl_sel_ext_fall: next_tick = eci_fall;
            cactl_pkg::cactl_sel_sysclk: next_tick = 1'b1;
            cactl_pkg::cactl_sel_extclk8: next_tick =
                extclk_rise && (ext8_cnt == cactl_pkg::div8_last);
            cactl_pkg::cactl_sel_lfo8: next_tick =
                lfo_rise && (lfo8_cnt == cactl_pkg::div8_last);
            cactl_pkg::cactl_sel_rsvd: next_tick = 1'b0;
        endcase
    end

    assign count_tick = next_tick && counter_run_bit && array_active;
    assign wrap = count_tick && (shared_array_counter == cactl_pkg::count_max);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shared_array_counter <= 16'h0000;
        end else if (count_tick) begin
            shared_array_counter <= shared_array_counter + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            counter_run_bit <= 1'b0;
        end else if (wr_ctrl) begin
            counter_run_bit <= reg_wdata[cactl_pkg::run_bit];
        end
    end

    // flags: a hardware set in the same cycle as a software clear wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            counter_overflow_flag <= 1'b0;
        end else if (wrap) begin
            counter_overflow_flag <= 1'b1;
        end else if (wr_ctrl) begin
            counter_overflow_flag <= reg_wdata[cactl_pkg::ovf_bit];
        end
    end

    // module events are dropped while the array is suspended
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            module_match_flag <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (module_match_event[i] && array_active) begin
                    module_match_flag[i] <= 1'b1;
                end else if (wr_ctrl) begin
                    module_match_flag[i] <= reg_wdata[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            idle_suspend_bit <= 1'b0;
        end else if (wr_mode) begin
            idle_suspend_bit <= reg_wdata[cactl_pkg::idle_bit];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            timebase_select <= 3'h0;
        end else if (wr_mode) begin
            timebase_select <= reg_wdata[cactl_pkg::sel_hi:cactl_pkg::sel_lo];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            overflow_irq_enable <= 1'b0;
        end else if (wr_mode) begin
            overflow_irq_enable <= reg_wdata[cactl_pkg::ovf_en_bit];
        end
    end

    // level request, drops only when software clears or masks every source
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            array_irq <= 1'b0;
        end else begin
            array_irq <= (counter_overflow_flag & overflow_irq_enable)
                | (|(module_match_flag & module_irq_enable));
        end
    end

    // reserved bits read as zero and writes to them are dropped
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_addr == cactl_pkg::ctrl_addr) begin
            reg_rdata = {counter_overflow_flag, counter_run_bit, 3'h0, module_match_flag};
        end else if (reg_addr == cactl_pkg::mode_addr) begin
            reg_rdata = {idle_suspend_bit, 3'h0, timebase_select, overflow_irq_enable};
        end
    end
endmodule

// file: include/cactl_pkg.sv
// constants for the counter array control block
// assumes an 8-bit special-function register port on the system clock
package cactl_pkg;
    localparam logic [7:0] ctrl_addr = 8'hd8;
    // the mode register has no printed address; this one is arbitrary
    localparam logic [7:0] mode_addr = 8'hd9;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] mode_reset = 8'h00;
    localparam int ovf_bit = 7;
    localparam int run_bit = 6;
    localparam int idle_bit = 7;
    localparam int sel_hi = 3;
    localparam int sel_lo = 1;
    localparam int ovf_en_bit = 0;
    localparam logic [7:0] ctrl_rsvd_mask = 8'h38;
    localparam logic [7:0] mode_rsvd_mask = 8'h70;
    localparam logic [3:0] div12_last = 4'hb;
    localparam logic [1:0] div4_last = 2'h3;
    localparam logic [2:0] div8_last = 3'h7;
    localparam logic [15:0] count_max = 16'hffff;
    typedef enum logic [2:0] {
        cactl_sel_div12 = 3'b000,
        cactl_sel_div4 = 3'b001,
        cactl_sel_tmr0 = 3'b010,
        cactl_sel_ext_fall = 3'b011,
        cactl_sel_sysclk = 3'b100,
        cactl_sel_extclk8 = 3'b101,
        cactl_sel_lfo8 = 3'b110,
        cactl_sel_rsvd = 3'b111
    } cactl_sel_e;
endpackage

// file: verification/cactl_chk.sv
// assertions on the counter array control ports
// assumes the single-cycle register port and one system clock
`timescale 1ns/10ps
module cactl_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic cpu_idle,
    input wire logic [2:0] module_match_event,
    input wire logic [2:0] module_irq_enable,
    input wire logic [15:0] shared_array_counter,
    input wire logic count_tick,
    input wire logic array_active,
    input wire logic array_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wrap_flag_a: assert property (count_tick && shared_array_counter == 16'hffff
        ##1 reg_addr == 8'hd8 |-> reg_rdata[7]) else $error("overflow flag missed");
    count_step_a: assert property (count_tick |=>
        shared_array_counter == $past(shared_array_counter) + 16'h1) else $error("bad step");
    count_hold_a: assert property (!count_tick |=> $stable(shared_array_counter))
        else $error("counter moved");
    flag_sticky_a: assert property (reg_addr == 8'hd8 && reg_rdata[7] && !reg_wr
        ##1 reg_addr == 8'hd8 |-> reg_rdata[7]) else $error("flag cleared");
    match_set_a: assert property (module_match_event[0] && array_active
        ##1 reg_addr == 8'hd8 |-> reg_rdata[0]) else $error("match flag missed");
    irq_raise_a: assert property (reg_addr == 8'hd8
        && (reg_rdata[2:0] & module_irq_enable) != 3'h0 |=> array_irq) else $error("no irq");
    irq_quiet_a: assert property (reg_addr == 8'hd8 && !reg_rdata[7]
        && (reg_rdata[2:0] & module_irq_enable) == 3'h0 |=> !array_irq) else $error("stray irq");
    idle_stop_a: assert property (!array_active |-> !count_tick)
        else $error("tick while suspended");
    rsvd_sel_a: assert property (reg_addr == 8'hd9 && reg_rdata[3:1] == 3'b111
        |-> !count_tick) else $error("tick on reserved select");
    cover property (count_tick && shared_array_counter == 16'hffff);
    cover property ($rose(array_irq));
    cover property (!array_active);
endmodule
bind cactl_top cactl_chk chk_u (.*);

// file: verification/counter_array_control_bench.sv
// self-checking bench for the counter array control block
// assumes the design top cactl_top and its package are compiled first
`timescale 1ns/10ps
module counter_array_control_bench;
    logic core_clk = 0, nrst = 0, reg_wr = 0, cpu_idle = 0, tmr = 0, tick, act, irq;
    logic [7:0] reg_addr = 8'hd8, reg_wdata = 8'h00, rv;
    logic [2:0] ev = 3'h0, en = 3'h0, pins = 3'h7, r;
    logic [15:0] cnt, c0;
    int n_mismatch = 0, checks_done = 0, seed = 57, k, i;
    int ex[4] = '{48, 12, 4, 0};
    logic [2:0] sl[4] = '{3'b100, 3'b001, 3'b000, 3'b111};
    logic [2:0] s2[3] = '{3'b011, 3'b101, 3'b110};
    always #12.5 core_clk = ~core_clk;
    cactl_top dut_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(rv), .cpu_idle(cpu_idle), .module_match_event(ev),
        .module_irq_enable(en), .timer0_overflow(tmr), .external_count_input(pins[0]),
        .external_clock(pins[1]), .lfo_clock(pins[2]), .shared_array_counter(cnt),
        .count_tick(tick), .array_active(act), .array_irq(irq));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        #1;
    endtask
    task mark;
        @(posedge core_clk);
        #1;
        c0 = cnt;
    endtask
    task span(input int n, input int e);
        mark;
        repeat (n) @(posedge core_clk);
        #1;
        chk(cnt - c0, 16'(e));
    endtask
    // one falling and one rising edge every 8 cycles keeps within clock div 4
    task wave(input int p, input int n);
        repeat (n) begin
            @(posedge core_clk);
            pins[p] <= 1'b0;
            repeat (4) @(posedge core_clk);
            pins[p] <= 1'b1;
            repeat (3) @(posedge core_clk);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (99000) @(posedge core_clk);
        n_mismatch++;
        conclude;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'hd8);
        chk({8'h00, rv}, 16'h0000);
        rd(8'hd9);
        chk({8'h00, rv}, 16'h0000);
        wr(8'hd8, 8'h40);
        for (k = 0; k < 4; k++) begin
            wr(8'hd9, {4'h0, sl[k], 1'b0});
            span(48, ex[k]);
        end
        wr(8'hd9, 8'h08);
        wr(8'hd8, 8'h00);
        span(20, 0);
        wr(8'hd8, 8'h40);
        for (k = 0; k < 3; k++) begin
            wr(8'hd9, {4'h0, s2[k], 1'b0});
            mark;
            wave(k, k == 0 ? 5 : 16);
            repeat (6) @(posedge core_clk);
            #1;
            chk(cnt - c0, k == 0 ? 16'h5 : 16'h2);
        end
        wr(8'hd9, 8'h04);
        mark;
        i = 1 + {$random(seed)} % 8;
        repeat (i) begin
            @(posedge core_clk);
            tmr <= 1'b1;
            @(posedge core_clk);
            tmr <= 1'b0;
        end
        @(posedge core_clk);
        #1;
        chk(cnt - c0, 16'(i));
        $display("test done: timebases");
        wr(8'hd9, 8'h88);
        cpu_idle <= 1'b1;
        span(20, 0);
        chk({15'h0, act}, 16'h0000);
        wr(8'hd9, 8'h08);
        span(20, 20);
        chk({15'h0, tick}, 16'h0001);
        cpu_idle <= 1'b0;
        for (k = 0; k < 8; k++) begin
            wr(8'hd8, 8'h40);
            r = 3'($random(seed));
            @(posedge core_clk);
            ev <= r;
            en <= 3'($random(seed));
            @(posedge core_clk);
            ev <= 3'h0;
            rd(8'hd8);
            chk({13'h0, rv[2:0]}, {13'h0, r});
            chk({15'h0, irq}, {15'h0, |(r & en)});
        end
        // module events in the very cycle of a clearing write must survive it
        @(posedge core_clk);
        reg_addr <= 8'hd8;
        reg_wdata <= 8'h40;
        reg_wr <= 1'b1;
        ev <= 3'h5;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        ev <= 3'h0;
        rd(8'hd8);
        chk({8'h00, rv}, 16'h0045);
        wr(8'hd8, 8'h40);
        rd(8'hd8);
        chk({8'h00, rv}, 16'h0040);
        $display("test done: match flags");
        wr(8'hd9, 8'h09);
        // the control register stays addressed so the wrap is seen by the checker
        rd(8'hd8);
        k = 0;
        while (cnt !== 16'hffff && k < 70000) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        @(posedge core_clk);
        #1;
        chk(cnt, 16'h0000);
        rd(8'hd8);
        chk({15'h0, rv[7]}, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        repeat (5) @(posedge core_clk);
        rd(8'hd8);
        chk({15'h0, rv[7]}, 16'h0001);
        wr(8'hd9, 8'h08);
        rd(8'hd8);
        chk({15'h0, irq}, 16'h0000);
        wr(8'hd8, 8'h40);
        rd(8'hd8);
        chk({15'h0, rv[7]}, 16'h0000);
        $display("test done: overflow");
        conclude;
    end
endmodule
